// *** fvs_status_one.sv ***
// fvs_status_one.sv - volatile status one register with its serial command front end
`timescale 1ns/10ps
module fvs_status_one
  import fvs_pkg::*;
#(
  parameter int ADDR_BYTES = 3
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   spi_sck,
  input  wire logic                   spi_cs_n,
  input  wire logic                   spi_si,
  output      logic                   spi_so,
  output      logic                   spi_so_oe,
  input  wire logic [7:0]             nonvolatile_status_one,
  input  wire logic [7:0]             nonvolatile_config_one,
  input  wire logic [7:0]             status_two_in,
  input  wire logic                   region_protected,
  output      logic [2:0]             protect_active,
  output      fvs_engine_req_s        engine_req,
  input  wire fvs_engine_rsp_s        engine_rsp,
  output      logic                   nv_wr_req,
  output      logic [7:0]             nv_wr_data,
  input  wire logic                   nv_wr_done,
  output      logic [7:0]             volatile_status_one
);

  // -------------------------------------------------------------------------
  // elaboration checks
  // -------------------------------------------------------------------------
  if (ADDR_BYTES != `FVS_ADDR_W / 8) begin : g_bad_addr
    $error("fvs_status_one: ADDR_BYTES must match the address width");
  end

  localparam logic [2:0] ADDR_LAST = 3'(ADDR_BYTES);

  // -------------------------------------------------------------------------
  // command classes
  // -------------------------------------------------------------------------
  function automatic logic is_clear_status_cmd(input logic [7:0] op);
    is_clear_status_cmd = (op == `FVS_OP_CLEAR_STATUS_CMD_A) || (op == `FVS_OP_CLEAR_STATUS_CMD_B);
  endfunction

  // the short list of opcodes that a busy device still takes
  function automatic logic busy_ok(input logic [7:0] op);
    busy_ok = (op == `FVS_OP_READ_STATUS_ONE_CMD) || (op == `FVS_OP_READ_STATUS_TWO_CMD) || (op == `FVS_OP_READ_ANY_REGISTER_CMD) ||
              (op == `FVS_OP_ERASE_PAUSE_CMD) || (op == `FVS_OP_PROGRAM_PAUSE_CMD) || (op == `FVS_OP_SRST) ||
              is_clear_status_cmd(op);
  endfunction

  function automatic logic [7:0] pack_status(input fvs_state_s st);
    pack_status = {st.lock_copy, st.p_err, st.e_err, st.bp, st.write_enable_latch,
                   st.phase != FVS_PH_IDLE};
  endfunction

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  fvs_state_s st_ff;
  fvs_state_s nxt_st;

  logic       sck_rise;
  logic       sck_fall;
  logic       cs_end;
  logic       busy;
  logic       exec_ok;
  logic [7:0] rx_byte;

  always_comb begin
    nxt_st = st_ff;
    rx_byte = {st_ff.shreg[6:0], st_ff.si_q};
    busy = st_ff.phase != FVS_PH_IDLE;
    exec_ok = !busy || busy_ok(st_ff.opcode);

    // synchronisers; only the second stage and later feed edge logic
    nxt_st.sck_m = spi_sck;
    nxt_st.sck_q = st_ff.sck_m;
    nxt_st.sck_p = st_ff.sck_q;
    nxt_st.cs_m = spi_cs_n;
    nxt_st.cs_q = st_ff.cs_m;
    nxt_st.cs_p = st_ff.cs_q;
    nxt_st.si_m = spi_si;
    nxt_st.si_q = st_ff.si_m;
    sck_rise = st_ff.sck_q & ~st_ff.sck_p;
    sck_fall = ~st_ff.sck_q & st_ff.sck_p;
    cs_end = st_ff.cs_q & ~st_ff.cs_p;

    nxt_st.req.start = 1'b0;
    nxt_st.req.pause_erase = 1'b0;
    nxt_st.req.pause_prog = 1'b0;
    nxt_st.nv_wr_req = 1'b0;
    nxt_st.lock_copy = nonvolatile_status_one[`FVS_BIT_LOCK];
    nxt_st.prot = nonvolatile_config_one[`FVS_CFG_BP_SRC] ? st_ff.bp
                : nonvolatile_status_one[`FVS_BP_HI:`FVS_BP_LO];

    // -----------------------------------------------------------------------
    // serial shifter, mode 0: sample on rise, drive on fall
    // -----------------------------------------------------------------------
    if (st_ff.cs_q) begin
      nxt_st.bit_cnt = 3'h0;
      nxt_st.byte_cnt = 3'h0;
      nxt_st.rd_on = 1'b0;
      nxt_st.so_oe = 1'b0;
    end else if (sck_rise) begin
      nxt_st.shreg = rx_byte;
      nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
      if (st_ff.bit_cnt == 3'h7) begin
        if (st_ff.byte_cnt != 3'h7) begin
          nxt_st.byte_cnt = st_ff.byte_cnt + 3'h1;
        end
        if (st_ff.byte_cnt == 3'h0) begin
          nxt_st.opcode = rx_byte;
          if (rx_byte == `FVS_OP_READ_STATUS_ONE_CMD) begin
            nxt_st.rd_on = 1'b1;
            nxt_st.out_sh = pack_status(st_ff);
          end else if (rx_byte == `FVS_OP_READ_STATUS_TWO_CMD) begin
            nxt_st.rd_on = 1'b1;
            nxt_st.out_sh = status_two_in;
          end
        end else begin
          nxt_st.data = rx_byte;
          if (st_ff.byte_cnt <= ADDR_LAST) begin
            nxt_st.addr = {st_ff.addr[`FVS_ADDR_W-9:0], rx_byte};
          end
          if (st_ff.opcode == `FVS_OP_READ_ANY_REGISTER_CMD && st_ff.byte_cnt == ADDR_LAST) begin
            nxt_st.rd_on = 1'b1;
          end
          // reads repeat with live status after the first byte
          if (st_ff.opcode == `FVS_OP_READ_STATUS_TWO_CMD) begin
            nxt_st.out_sh = status_two_in;
          end else begin
            nxt_st.out_sh = pack_status(st_ff);
          end
        end
      end
    end else if (sck_fall && st_ff.rd_on) begin
      nxt_st.so = st_ff.out_sh[7];
      nxt_st.out_sh = {st_ff.out_sh[6:0], 1'b0};
      nxt_st.so_oe = 1'b1;
    end

    // -----------------------------------------------------------------------
    // command execution when chip select rises on a byte boundary
    // -----------------------------------------------------------------------
    if (cs_end && st_ff.bit_cnt == 3'h0 && st_ff.byte_cnt != 3'h0 && exec_ok) begin
      case (st_ff.opcode)
        `FVS_OP_SET_WRITE_LATCH_CMD: begin
          nxt_st.write_enable_latch = 1'b1;
        end
        `FVS_OP_CLEAR_WRITE_LATCH_CMD: begin
          nxt_st.write_enable_latch = 1'b0;
        end
        `FVS_OP_CLEAR_STATUS_CMD_A, `FVS_OP_CLEAR_STATUS_CMD_B: begin
          nxt_st.p_err = 1'b0;
          nxt_st.e_err = 1'b0;
          if (st_ff.phase == FVS_PH_FAULT) begin
            nxt_st.phase = FVS_PH_IDLE;
          end
        end
        `FVS_OP_SRST: begin
          nxt_st.load_pend = 1'b1;
        end
        `FVS_OP_WRR: begin
          if (st_ff.write_enable_latch && st_ff.byte_cnt >= 3'h2) begin
            if (nonvolatile_config_one[`FVS_CFG_BP_SRC]) begin
              nxt_st.bp = st_ff.data[`FVS_BP_HI:`FVS_BP_LO];
              nxt_st.write_enable_latch = 1'b0;
            end else begin
              nxt_st.nv_wr_req = 1'b1;
              nxt_st.nv_wr_data = nonvolatile_status_one;
              nxt_st.nv_wr_data[`FVS_BIT_LOCK] = st_ff.data[`FVS_BIT_LOCK];
              nxt_st.nv_wr_data[`FVS_BP_HI:`FVS_BP_LO] = st_ff.data[`FVS_BP_HI:`FVS_BP_LO];
              nxt_st.phase = FVS_PH_NVWR;
            end
          end
        end
        `FVS_OP_PP, `FVS_OP_SE: begin
          if (st_ff.write_enable_latch && st_ff.byte_cnt > ADDR_LAST) begin
            if (region_protected) begin
              if (st_ff.opcode == `FVS_OP_PP) begin
                nxt_st.p_err = 1'b1;
              end else begin
                nxt_st.e_err = 1'b1;
              end
              nxt_st.phase = FVS_PH_FAULT;
            end else begin
              nxt_st.req.start = 1'b1;
              nxt_st.req.kind = (st_ff.opcode == `FVS_OP_PP) ? FVS_OP_PROG : FVS_OP_ERASE;
              nxt_st.req.addr = st_ff.addr;
              nxt_st.phase = FVS_PH_ARRAY;
            end
          end
        end
        `FVS_OP_BE: begin
          if (st_ff.write_enable_latch && st_ff.prot == 3'h0) begin
            nxt_st.req.start = 1'b1;
            nxt_st.req.kind = FVS_OP_BULK;
            nxt_st.phase = FVS_PH_ARRAY;
          end
        end
        `FVS_OP_ERASE_PAUSE_CMD: begin
          if (st_ff.phase == FVS_PH_ARRAY && st_ff.req.kind != FVS_OP_PROG) begin
            nxt_st.req.pause_erase = 1'b1;
          end
        end
        `FVS_OP_PROGRAM_PAUSE_CMD: begin
          if (st_ff.phase == FVS_PH_ARRAY && st_ff.req.kind == FVS_OP_PROG) begin
            nxt_st.req.pause_prog = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // -----------------------------------------------------------------------
    // operation phases; evaluated after commands so a failure beats a clear
    // -----------------------------------------------------------------------
    case (st_ff.phase)
      FVS_PH_ARRAY: begin
        if (engine_rsp.done) begin
          if (!engine_rsp.fail) begin
            nxt_st.phase = FVS_PH_IDLE;
            nxt_st.write_enable_latch = 1'b0;
          end else if (st_ff.req.kind == FVS_OP_BULK && engine_rsp.protect_hit) begin
            nxt_st.phase = FVS_PH_IDLE;
          end else begin
            if (st_ff.req.kind == FVS_OP_PROG) begin
              nxt_st.p_err = 1'b1;
            end else begin
              nxt_st.e_err = 1'b1;
            end
            nxt_st.phase = FVS_PH_FAULT;
          end
        end
      end
      FVS_PH_NVWR: begin
        if (nv_wr_done) begin
          nxt_st.bp = st_ff.nv_wr_data[`FVS_BP_HI:`FVS_BP_LO];
          nxt_st.write_enable_latch = 1'b0;
          nxt_st.phase = FVS_PH_IDLE;
        end
      end
      FVS_PH_IDLE, FVS_PH_FAULT: begin
      end
      default: begin
        nxt_st.phase = FVS_PH_IDLE;
      end
    endcase

    // reload from the non-volatile defaults a cycle after any reset, so the
    // reset branch itself only ever loads constants
    if (st_ff.load_pend) begin
      nxt_st.load_pend = 1'b0;
      nxt_st.p_err = nonvolatile_status_one[`FVS_BIT_PERR];
      nxt_st.e_err = nonvolatile_status_one[`FVS_BIT_EERR];
      nxt_st.bp = nonvolatile_status_one[`FVS_BP_HI:`FVS_BP_LO];
      nxt_st.write_enable_latch = 1'b0;
      nxt_st.phase = FVS_PH_IDLE;
    end
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.sck_m <= 1'b0;
      st_ff.cs_m <= 1'b1;
      st_ff.cs_q <= 1'b1;
      st_ff.cs_p <= 1'b1;
      st_ff.load_pend <= 1'b1;
      st_ff.phase <= FVS_PH_IDLE;
      st_ff.bp <= `FVS_RST_BP;
      st_ff.out_sh <= `FVS_RST_BYTE;
      st_ff.write_enable_latch <= 1'b0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------------
  // outputs, all from flip-flops except the busy bit of volatile_status_one, decoded from phase
  // -------------------------------------------------------------------------
  assign spi_so = st_ff.so;
  assign spi_so_oe = st_ff.so_oe;
  assign protect_active = st_ff.prot;
  assign engine_req = st_ff.req;
  assign nv_wr_req = st_ff.nv_wr_req;
  assign nv_wr_data = st_ff.nv_wr_data;
  assign volatile_status_one = pack_status(st_ff);

endmodule // fvs_status_one

// *** fvs_cfg.svh ***
// fvs_cfg.svh - opcodes, field positions and reset values of volatile status one
`ifndef FVS_CFG_SVH
`define FVS_CFG_SVH

`define FVS_ADDR_W          24
`define FVS_OP_SET_WRITE_LATCH_CMD         8'h06
`define FVS_OP_CLEAR_WRITE_LATCH_CMD         8'h04
`define FVS_OP_CLEAR_STATUS_CMD_A       8'h30
`define FVS_OP_CLEAR_STATUS_CMD_B       8'h82
`define FVS_OP_READ_ANY_REGISTER_CMD         8'h65
`define FVS_OP_READ_STATUS_ONE_CMD        8'h05
`define FVS_OP_READ_STATUS_TWO_CMD        8'h07
`define FVS_OP_WRR          8'h01
`define FVS_OP_PP           8'h02
`define FVS_OP_SE           8'hd8
`define FVS_OP_BE           8'h60
`define FVS_OP_ERASE_PAUSE_CMD         8'h75
`define FVS_OP_PROGRAM_PAUSE_CMD         8'h85
`define FVS_OP_SRST         8'hf0
`define FVS_BIT_LOCK        7
`define FVS_BIT_PERR        6
`define FVS_BIT_EERR        5
`define FVS_BP_HI           4
`define FVS_BP_LO           2
`define FVS_BIT_WEL         1
`define FVS_BIT_BUSY        0
`define FVS_CFG_BP_SRC      3
`define FVS_RST_BP          3'h0
`define FVS_RST_BYTE        8'h00

`endif

// *** fvs_pkg.sv ***
// fvs_pkg.sv - types shared by the volatile status one block
`include "fvs_cfg.svh"
package fvs_pkg;

  typedef enum logic [3:0] {
    FVS_PH_IDLE  = 4'b0001,
    FVS_PH_ARRAY = 4'b0010,
    FVS_PH_NVWR  = 4'b0100,
    FVS_PH_FAULT = 4'b1000
  } fvs_phase_e;

  typedef enum logic [1:0] {
    FVS_OP_PROG  = 2'h0,
    FVS_OP_ERASE = 2'h1,
    FVS_OP_BULK  = 2'h2
  } fvs_op_e;

  typedef struct packed {
    logic                   start;
    fvs_op_e                kind;
    logic [`FVS_ADDR_W-1:0] addr;
    logic                   pause_erase;
    logic                   pause_prog;
  } fvs_engine_req_s;

  typedef struct packed {
    logic done;
    logic fail;
    logic protect_hit;
  } fvs_engine_rsp_s;

  typedef struct packed {
    logic                   sck_m, sck_q, sck_p;
    logic                   cs_m, cs_q, cs_p;
    logic                   si_m, si_q;
    logic [2:0]             bit_cnt;
    logic [2:0]             byte_cnt;
    logic [7:0]             shreg;
    logic [7:0]             opcode;
    logic [7:0]             data;
    logic [`FVS_ADDR_W-1:0] addr;
    logic [7:0]             out_sh;
    logic                   rd_on;
    logic                   so;
    logic                   so_oe;
    logic                   load_pend;
    fvs_phase_e             phase;
    logic                   lock_copy;
    logic                   p_err;
    logic                   e_err;
    logic [2:0]             bp;
    logic [2:0]             prot;
    logic                   write_enable_latch;
    fvs_engine_req_s        req;
    logic                   nv_wr_req;
    logic [7:0]             nv_wr_data;
  } fvs_state_s;

endpackage

// *** fvs_checker.sv ***
// fvs_checker.sv - port-level checks of the volatile status one block
`timescale 1ns/10ps
module fvs_checker
  import fvs_pkg::*;
#(
  parameter int ADDR_BYTES = 3
) (
  input wire logic            sys_clk,
  input wire logic            reset,
  input wire logic            clk_en,
  input wire logic            spi_sck,
  input wire logic            spi_cs_n,
  input wire logic            spi_si,
  input wire logic            spi_so,
  input wire logic            spi_so_oe,
  input wire logic [7:0]      nonvolatile_status_one,
  input wire logic [7:0]      nonvolatile_config_one,
  input wire logic [7:0]      status_two_in,
  input wire logic            region_protected,
  input wire logic [2:0]      protect_active,
  input wire fvs_engine_req_s engine_req,
  input wire fvs_engine_rsp_s engine_rsp,
  input wire logic            nv_wr_req,
  input wire logic [7:0]      nv_wr_data,
  input wire logic            nv_wr_done,
  input wire logic [7:0]      volatile_status_one
);
  logic [7:0] st;
  assign st = volatile_status_one;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // engine finishing cleanly while an operation is open
  sequence s_ok_done;
    engine_rsp.done && !engine_rsp.fail && st[0];
  endsequence
  property p_lock; $past(clk_en) && !$past(reset) |-> st[7] == $past(nonvolatile_status_one[7]); endproperty
  a_lock: assert property (p_lock) else $error("lock copy lost");
  property p_wel_up; $rose(st[1]) |-> $past(spi_cs_n, 3) && !st[0]; endproperty
  a_wel_up: assert property (p_wel_up) else $error("latch rose wrongly");
  property p_err_busy; $rose(st[6]) || $rose(st[5]) |-> st[0]; endproperty
  a_err_busy: assert property (p_err_busy) else $error("error without busy");
  property p_ok_done; s_ok_done |=> !st[0] && !st[1]; endproperty
  a_ok_done: assert property (p_ok_done) else $error("clean end kept state");
  property p_fail; engine_rsp.done && engine_rsp.fail && !engine_rsp.protect_hit
    |=> st[0] && (st[6] || st[5]); endproperty
  a_fail: assert property (p_fail) else $error("failure not flagged");
  property p_start; engine_req.start |-> $past(st[1], 2) && !$past(st[0], 2); endproperty
  a_start: assert property (p_start) else $error("start without latch");
  property p_bulk; engine_req.start && engine_req.kind == FVS_OP_BULK
    |-> $past(protect_active, 2) == 3'h0; endproperty
  a_bulk: assert property (p_bulk) else $error("bulk under protection");
  property p_pause; engine_req.pause_erase || engine_req.pause_prog |-> $past(st[0]); endproperty
  a_pause: assert property (p_pause) else $error("pause while idle");
endmodule // fvs_checker

bind fvs_status_one fvs_checker #(.ADDR_BYTES(ADDR_BYTES)) u_chk (.*);

// *** fvs_engine_model.sv ***
// fvs_engine_model.sv - array engine and non-volatile store beside the block
`timescale 1ns/10ps
module fvs_engine_model
  import fvs_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            reset,
  input  wire logic [7:0]      dly,
  input  wire logic            fail_mode,
  input  wire logic            hit_mode,
  input  wire fvs_engine_req_s engine_req,
  output      fvs_engine_rsp_s engine_rsp,
  input  wire logic            nv_wr_req,
  input  wire logic [7:0]      nv_wr_data,
  output      logic            nv_wr_done,
  output      logic [7:0]      nv_q
);
  logic [8:0] cnt;
  logic       run;
  logic       nvrun;
  always_ff @(posedge sys_clk) begin
    // result lines carry junk outside the done cycle
    engine_rsp <= {1'b0, ~fail_mode, ~hit_mode};
    nv_wr_done <= 1'b0;
    if (reset) begin
      run <= 1'b0;
      nvrun <= 1'b0;
      cnt <= 9'h000;
      nv_q <= 8'h80;
    end else if (engine_req.start) begin
      run <= 1'b1;
      cnt <= {dly, 1'b0};
    end else if (nv_wr_req) begin
      nvrun <= 1'b1;
      cnt <= {dly, 1'b0};
      nv_q <= nv_wr_data;
    end else if (cnt != 9'h000) begin
      cnt <= cnt - 9'h001;
    end else if (run) begin
      run <= 1'b0;
      engine_rsp <= {1'b1, fail_mode, hit_mode};
    end else if (nvrun) begin
      nvrun <= 1'b0;
      nv_wr_done <= 1'b1;
    end
  end
endmodule // fvs_engine_model

// *** tb.sv ***
// tb.sv - command-level bench for the volatile status one block
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import fvs_pkg::*;
  logic            sys_clk, reset, sck, cs_n, si, rgn, fail_m, hit_m, en;
  logic [7:0]      cfg, dly, rd, nv_q, nv_d, st;
  logic [2:0]      pa;
  logic            so, so_oe, nv_req, nv_done;
  fvs_engine_req_s req;
  fvs_engine_rsp_s rsp;
  int              err_total, tests_run, pe_n, pp_n;

  fvs_status_one dut (.sys_clk(sys_clk), .reset(reset), .clk_en(en), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
    .nonvolatile_status_one(nv_q), .nonvolatile_config_one(cfg), .status_two_in(8'h5a),
    .region_protected(rgn), .protect_active(pa), .engine_req(req), .engine_rsp(rsp),
    .nv_wr_req(nv_req), .nv_wr_data(nv_d), .nv_wr_done(nv_done), .volatile_status_one(st));
  fvs_engine_model eng (.sys_clk(sys_clk), .reset(reset), .dly(dly), .fail_mode(fail_m),
    .hit_mode(hit_m), .engine_req(req), .engine_rsp(rsp), .nv_wr_req(nv_req),
    .nv_wr_data(nv_d), .nv_wr_done(nv_done), .nv_q(nv_q));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (req.pause_erase === 1'b1) pe_n++;
    if (req.pause_prog === 1'b1) pp_n++;
  end

  task automatic test_done();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // mode 0 frame, msb first; sck only toggles inside the frame
  task automatic xfer(input int nb, input logic [31:0] d);
    @(negedge sys_clk);
    cs_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      si = d[i];
      repeat (4) @(negedge sys_clk);
      sck = 1'b1;
      repeat (4) @(negedge sys_clk);
      rd = {rd[6:0], so};
      sck = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1'b1;
    repeat (12) @(negedge sys_clk);
  endtask
  task automatic chk_st(input logic [7:0] e);
    xfer(2, {8'h05, 8'h00});
    `CHK(rd, e)
    `CHK(st, e)
    `CHK(so_oe, 1'b0)
  endtask
  task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
    int n;
    for (n = 0; n < 800 && (st & m) !== v; n++) @(negedge sys_clk);
    if (n == 800) begin
      err_total++;
      test_done();
    end
  endtask

  initial begin
    reset = 1'b1;
    en = 1'b1;
    {sck, si, rgn, fail_m, hit_m, cs_n} = 6'h01;
    {cfg, dly, rd} = {8'h00, 8'hff, 8'h00};
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk_st(8'h80);
    // a frozen block must not see a frame sent while its enable is low
    en = 1'b0;
    xfer(1, 8'h06);
    en = 1'b1;
    chk_st(8'h80);
    xfer(4, {8'h02, 24'h000100});
    chk_st(8'h80);
    xfer(1, 8'h06);
    xfer(4, {8'h02, 24'h000100});
    xfer(1, 8'h04);
    chk_st(8'h83);
    wait_st(8'h01, 8'h00);
    chk_st(8'h80);
    for (int k = 0; k < 3; k++) begin
      rgn = (k == 1);
      fail_m = (k != 1);
      xfer(1, 8'h06);
      xfer(4, {((k == 2) ? 8'hd8 : 8'h02), 24'h000100});
      wait_st(8'h61, (k == 2) ? 8'h21 : 8'h41);
      chk_st((k == 2) ? 8'ha3 : 8'hc3);
      xfer(1, (k == 1) ? 8'h82 : 8'h30);
      `CHK(st & 8'hfd, 8'h80)
      xfer(1, 8'h04);
    end
    {rgn, hit_m} = 2'b01;
    xfer(1, 8'h06);
    xfer(1, 8'h60);
    wait_st(8'h01, 8'h00);
    chk_st(8'h82);
    {fail_m, hit_m} = 2'b00;
    xfer(1, 8'h75);
    xfer(4, {8'hd8, 24'h000100});
    xfer(1, 8'h85);
    xfer(1, 8'h75);
    `CHK({pe_n, pp_n}, {32'd1, 32'd0})
    `CHK(req.addr, 24'h000100)
    wait_st(8'h01, 8'h00);
    xfer(1, 8'h06);
    xfer(2, {8'h01, 8'h9c});
    wait_st(8'h01, 8'h00);
    chk_st(8'h9c);
    `CHK({nv_q, pa}, {8'h9c, 3'h7})
    xfer(1, 8'h06);
    xfer(1, 8'h60);
    chk_st(8'h9e);
    cfg = 8'h08;
    xfer(2, {8'h01, 8'h00});
    chk_st(8'h80);
    `CHK({nv_q, pa}, {8'h9c, 3'h0})
    xfer(1, 8'h06);
    xfer(1, 8'hf0);
    chk_st(8'h9c);
    cfg = 8'h00;
    xfer(1, 8'h06);
    xfer(2, {8'h01, 8'h00});
    wait_st(8'h01, 8'h00);
    chk_st(8'h00);
    test_done();
  end
endmodule // tb
